// file: rtl/sld_pkg.sv
// Constants, types and decode helpers for the synthesizer status/lock block.
// Assumes a single 10 MHz core clock; analog levels arrive as comparator flags.
// Operation
// - Status byte shifted out most significant bit first
// - Two programmable address bits allow four devices
// - Address bits follow address-select pin voltage level
// - Sense pin level encoded into three-bit code
// - Lock indicator rises 1024 to 1152 us after lock
// - Lock indicator falls within 128 us of unlock
// - Current-select bit picks high or low pump current
// - Drive-disable bit switches tuning drive amplifier off
// - Lock indicator readable as status bit
// - Code bits sit lowest in status byte
// - Answer only a matching seven-bit address plus direction
package sld_pkg;

  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CMP_PERIOD_US = 128;
  localparam int unsigned CMP_PERIOD_CYC = CMP_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LOCK_SET_MIN_US = 1024;
  localparam int unsigned LOCK_SET_MAX_US = 1152;
  localparam int unsigned UNLOCK_MAX_US = 128;
  localparam int unsigned LOCK_PERIODS = LOCK_SET_MIN_US / CMP_PERIOD_US;

  // Fixed upper part of the slave address, then the two select bits and direction
  localparam logic [4:0] ADDR_FIXED = 5'h18;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Control byte layout
  localparam int unsigned CTRL_FLAG_BIT = 7;
  localparam int unsigned CURR_SEL_BIT = 6;
  localparam int unsigned TRI_TEST_BIT = 4;
  localparam int unsigned DRV_OFF_BIT = 0;

  // Write byte order after auto-increment
  localparam logic [1:0] IDX_DIV_HI = 2'h0;
  localparam logic [1:0] IDX_CTRL = 2'h2;
  localparam logic [1:0] IDX_PORT = 2'h3;

  // Converter codes
  localparam logic [2:0] CODE_L4 = 3'h4;
  localparam logic [2:0] CODE_L3 = 3'h3;
  localparam logic [2:0] CODE_L2 = 3'h2;
  localparam logic [2:0] CODE_L1 = 3'h1;
  localparam logic [2:0] CODE_L0 = 3'h0;

  // Address-select decodes
  localparam logic [1:0] MA_LOW = 2'h0;
  localparam logic [1:0] MA_OPEN = 2'h1;
  localparam logic [1:0] MA_MID = 2'h2;
  localparam logic [1:0] MA_HIGH = 2'h3;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WDAT = 7'h08,
    ST_WACK = 7'h10,
    ST_RDAT = 7'h20,
    ST_RACK = 7'h40
  } sld_state_t;

  // Thermometer flags (>=0.15, >=0.3, >=0.45, >=0.6 of supply) to code
  function automatic logic [2:0] sld_sense_code(input logic [3:0] cmp);
    if (cmp[3]) return CODE_L4;
    else if (cmp[2]) return CODE_L3;
    else if (cmp[1]) return CODE_L2;
    else if (cmp[0]) return CODE_L1;
    else return CODE_L0;
  endfunction

  // Address pin flags {high>=0.9, mid 0.4..0.6, low<0.1}; none means open
  function automatic logic [1:0] sld_addr_bits(input logic [2:0] cmp);
    if (cmp[0]) return MA_LOW;
    else if (cmp[1]) return MA_MID;
    else if (cmp[2]) return MA_HIGH;
    else return MA_OPEN;
  endfunction

endpackage

// file: rtl/sld_lock_if.sv
// Interface between the status controller and the lock detector.
// Both ends run on core_clk; in_phase is already synchronised.
`timescale 1ns/1ps
`default_nettype none
interface sld_lock_if;
  logic in_phase;
  logic locked;
  modport det (input in_phase, output locked);
  modport ctl (output in_phase, input locked);
endinterface
`default_nettype wire

// file: rtl/sld_lock_det.sv
// Lock detector: counts clean comparison periods from a core_clk divider.
// Assumes in_phase is synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module sld_lock_det
  import sld_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = CMP_PERIOD_CYC,
  parameter int unsigned NUM_PERIODS = LOCK_PERIODS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  sld_lock_if.det lk
);
  localparam int unsigned PW = $clog2(PERIOD_CYC);
  localparam int unsigned GW = $clog2(NUM_PERIODS + 1);
  localparam logic [PW-1:0] PERIOD_LAST = PW'(PERIOD_CYC - 1);
  localparam logic [GW-1:0] GOOD_LAST = GW'(NUM_PERIODS - 1);

  logic [PW-1:0] period_cnt_q;
  logic [GW-1:0] good_cnt_q;
  logic dirty_q;
  logic locked_q;
  wire tick = (period_cnt_q == PERIOD_LAST);
  wire clean_end = tick && !dirty_q && lk.in_phase;

  // Comparison period divider
  always_ff @(posedge core_clk) begin
    if (!reset_n) period_cnt_q <= '0;
    else if (tick) period_cnt_q <= '0;
    else period_cnt_q <= period_cnt_q + 1'b1;
  end

  // Any unlocked sample spoils the whole period, so a partial period never counts
  always_ff @(posedge core_clk) begin
    if (!reset_n) dirty_q <= 1'b1;
    else if (tick) dirty_q <= 1'b0;
    else if (!lk.in_phase) dirty_q <= 1'b1;
  end

  // Clean-period count and indicator
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      good_cnt_q <= '0;
      locked_q <= 1'b0;
    end else if (!lk.in_phase) begin
      good_cnt_q <= '0;
      locked_q <= 1'b0;
    end else if (tick) begin
      good_cnt_q <= clean_end ? good_cnt_q + 1'b1 : '0;
      if (clean_end && good_cnt_q == GOOD_LAST) locked_q <= 1'b1;
    end
  end

  assign lk.locked = locked_q;

  // Helper: cycles of unbroken in-phase, saturating
  logic [15:0] run_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n || !lk.in_phase) run_q <= '0;
    else if (run_q != 16'hFFFF) run_q <= run_q + 1'b1;
  end
  localparam int unsigned RUN_MIN = NUM_PERIODS * PERIOD_CYC - 1;
  localparam int unsigned RUN_MAX = (NUM_PERIODS + 1) * PERIOD_CYC;

  a_lock_too_early: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(locked_q) |-> run_q >= RUN_MIN) else $error("lock indicator rose too early");
  a_lock_too_late: assert property (@(posedge core_clk) disable iff (!reset_n)
    run_q == RUN_MAX |-> locked_q) else $error("lock indicator rose too late");
  a_unlock_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
    !lk.in_phase |=> !locked_q) else $error("lock indicator not cleared on unlock");
endmodule // sld_lock_det
`default_nettype wire

// file: rtl/sld_top.sv
// Status and control side of the synthesizer: serial slave, address select,
// converter encode, lock indicator, pump and drive control bits.
// Assumes all pin inputs are asynchronous to core_clk; the bus clock is sampled.
`timescale 1ns/1ps
`default_nettype none
module sld_top
  import sld_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = CMP_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [3:0] analog_sense_pin,
  input wire logic [2:0] address_select_pin,
  input wire logic [2:0] port_input,
  input wire logic supply_low,
  input wire logic loop_in_phase,
  output logic address_select_bit_hi,
  output logic address_select_bit_lo,
  output logic conversion_code_bit2,
  output logic conversion_code_bit1,
  output logic conversion_code_bit0,
  output logic phase_locked_indicator,
  output logic power_on_flag,
  output logic pump_current_select,
  output logic pump_tristate_test,
  output logic drive_disable,
  output logic tuning_drive_enable
);
  localparam int unsigned SW = 14;

  // Bus lines reset to their idle high level, so no false edge follows reset
  localparam logic [SW-1:0] SYNC_IDLE = {2'h3, {(SW - 2){1'b0}}};

  // Two-flop synchroniser for every pin input
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= {scl_pin, sda_in, analog_sense_pin, address_select_pin, port_input,
                  supply_low, loop_in_phase};
      sync2_q <= sync1_q;
    end
  end

  // Named views of the synchronised inputs
  wire scl_s = sync2_q[13];
  wire sda_s = sync2_q[12];
  wire [3:0] sense_s = sync2_q[11:8];
  wire [2:0] addr_s = sync2_q[7:5];
  wire [2:0] port_s = sync2_q[4:2];
  wire supply_low_s = sync2_q[1];
  wire in_phase_s = sync2_q[0];

  // Delayed copies for edge finding on the sampled bus lines
  logic scl_d_q;
  logic sda_d_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end
  wire scl_rise = scl_s && !scl_d_q;
  wire scl_fall = !scl_s && scl_d_q;
  wire start_seen = scl_s && scl_d_q && sda_d_q && !sda_s;
  wire stop_seen = scl_s && scl_d_q && !sda_d_q && sda_s;

  // Lock detector
  sld_lock_if lk ();
  assign lk.in_phase = in_phase_s;
  sld_lock_det #(.PERIOD_CYC(PERIOD_CYC), .NUM_PERIODS(LOCK_PERIODS)) u_lock (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .lk(lk)
  );

  // Level decodes, registered so the status byte sees stable bits
  wire [1:0] ma_w = sld_addr_bits(addr_s);
  wire [2:0] code_w = sld_sense_code(sense_s);
  logic [1:0] ma_q;
  logic [2:0] code_q;
  logic lock_ind_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ma_q <= MA_OPEN;
      code_q <= CODE_L0;
      lock_ind_q <= 1'b0;
    end else begin
      ma_q <= ma_w;
      code_q <= code_w;
      lock_ind_q <= lk.locked;
    end
  end

  logic por_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic oe_n_q;
  logic rw_q;
  logic first_q;
  logic [1:0] widx_q;
  logic curr_sel_q;
  logic tri_test_q;
  logic drv_off_q;
  sld_state_t state_q;

  // Status byte and address compare
  wire [7:0] status_w = {por_q, lock_ind_q, port_s, code_q};
  wire addr_match = (shift_q[7:1] == {ADDR_FIXED, ma_q});
  wire byte_done = scl_fall && (cnt_q == BYTE_BITS);
  wire [1:0] next_idx = first_q ? (shift_q[CTRL_FLAG_BIT] ? IDX_CTRL : IDX_DIV_HI)
                      : (widx_q == IDX_PORT) ? IDX_PORT : widx_q + 2'h1;
  wire rd_end = (state_q == ST_RACK) && scl_rise && sda_s;

  // Serial slave; a start or stop overrides any state mid-byte
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      oe_n_q <= 1'b1;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      widx_q <= IDX_DIV_HI;
      curr_sel_q <= 1'b0;
      tri_test_q <= 1'b0;
      drv_off_q <= 1'b0;
    end else if (stop_seen) begin
      state_q <= ST_IDLE;
      oe_n_q <= 1'b1;
    end else if (start_seen) begin
      state_q <= ST_ADDR;
      cnt_q <= 4'h0;
      oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q <= 4'h0;
            if (addr_match) begin
              oe_n_q <= 1'b0;
              rw_q <= shift_q[0];
              state_q <= ST_AACK;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            first_q <= 1'b1;
            if (rw_q) begin
              shift_q <= status_w;
              oe_n_q <= status_w[7];
              state_q <= ST_RDAT;
            end else begin
              oe_n_q <= 1'b1;
              state_q <= ST_WDAT;
            end
          end
        end
        ST_WDAT: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q <= 4'h0;
            oe_n_q <= 1'b0;
            first_q <= 1'b0;
            widx_q <= next_idx;
            state_q <= ST_WACK;
            if (next_idx == IDX_CTRL) begin
              curr_sel_q <= shift_q[CURR_SEL_BIT];
              tri_test_q <= shift_q[TRI_TEST_BIT];
              drv_off_q <= shift_q[DRV_OFF_BIT];
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            oe_n_q <= 1'b1;
            state_q <= ST_WDAT;
          end
        end
        ST_RDAT: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            cnt_q <= 4'h0;
            oe_n_q <= 1'b1;
            state_q <= ST_RACK;
          end else if (scl_fall) begin
            shift_q <= {shift_q[6:0], 1'b0};
            oe_n_q <= shift_q[6];
          end
        end
        ST_RACK: begin
          if (rd_end) begin
            state_q <= ST_IDLE; // No acknowledge: bus released
          end else if (scl_fall) begin
            shift_q <= status_w;
            oe_n_q <= status_w[7];
            state_q <= ST_RDAT;
          end
        end
        ST_IDLE: begin
          oe_n_q <= 1'b1;
        end
        default: begin
          state_q <= ST_IDLE;
          oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // Power-on flag; a supply dip in the same cycle as end of read wins
  always_ff @(posedge core_clk) begin
    if (!reset_n) por_q <= 1'b1;
    else if (supply_low_s) por_q <= 1'b1;
    else if (rd_end) por_q <= 1'b0;
  end

  // Output flops
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tuning_drive_enable <= 1'b1;
      phase_locked_indicator <= 1'b0;
    end else begin
      tuning_drive_enable <= !drv_off_q;
      phase_locked_indicator <= lock_ind_q;
    end
  end

  assign sda_out = 1'b0; // Open drain: only ever pulls low
  assign sda_oe_n = oe_n_q;
  assign address_select_bit_hi = ma_q[1];
  assign address_select_bit_lo = ma_q[0];
  assign conversion_code_bit2 = code_q[2];
  assign conversion_code_bit1 = code_q[1];
  assign conversion_code_bit0 = code_q[0];
  assign power_on_flag = por_q;
  assign pump_current_select = curr_sel_q;
  assign pump_tristate_test = tri_test_q;
  assign drive_disable = drv_off_q;

  a_status_msb_first: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_AACK && scl_fall && rw_q && !stop_seen && !start_seen)
    |=> oe_n_q == $past(status_w[7])) else $error("status byte not MSB first");
  a_addr_nomatch: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_ADDR && byte_done && !addr_match && !stop_seen && !start_seen)
    |=> state_q == ST_IDLE && oe_n_q) else $error("answered a foreign address");
  a_drive_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(drv_off_q) |=> !tuning_drive_enable) else $error("drive not switched off");
  a_sense_code: assert property (@(posedge core_clk) disable iff (!reset_n)
    $stable(sense_s) |=> code_q == sld_sense_code($past(sense_s)))
    else $error("converter code wrong");
  a_addr_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    $stable(addr_s) |=> ma_q == sld_addr_bits($past(addr_s)))
    else $error("address bits wrong");
  a_status_lock: assert property (@(posedge core_clk) disable iff (!reset_n)
    lk.locked |-> ##2 phase_locked_indicator) else $error("lock bit not shown");
endmodule // sld_top
`default_nettype wire

// file: verif/sld_bus_master.sv
// Behavioural two-wire bus controller driving the device's bus pins.
// Assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module sld_bus_master (
  input wire logic core_clk,
  output logic scl,
  output logic sda_drv,
  input wire logic sda_bus
);
  logic slow;
  // Bus idles released
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
    slow = 1'h0;
  end
  // Quarter bit time; slow mode stretches the bus clock
  task automatic q();
    repeat (slow ? 4 : 2) @(posedge core_clk);
    #1;
  endtask
  task automatic start();
    sda_drv = 1'h1;
    q();
    scl = 1'h1;
    q();
    sda_drv = 1'h0;
    q();
    scl = 1'h0;
    q();
  endtask
  task automatic stop();
    sda_drv = 1'h0;
    q();
    scl = 1'h1;
    q();
    sda_drv = 1'h1;
    q();
  endtask
  // Data moves only while the clock is low, read mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    q();
    scl = 1'h1;
    q();
    r = sda_bus;
    q();
    scl = 1'h0;
    q();
  endtask
  // Seven address bits plus direction, or a data byte, MSB first
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'h1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(last, r); // A missing acknowledge ends the read
  endtask
endmodule // sld_bus_master
`default_nettype wire

// file: verif/synth_status_lock_detect_tb_top.sv
// Self-checking bench: pin decodes, control writes, status reads, lock timing.
// Assumes a pull-up on the bus data line and a shortened comparison period.
`timescale 1ns/1ps
`default_nettype none
module synth_status_lock_detect_tb_top;
  localparam int unsigned P = 16;
  logic core_clk, reset_n, scl, m_sda, sda_in, sda_out, sda_oe_n;
  logic [3:0] sense;
  logic [2:0] adr_pin, port_in, r, e3;
  logic supply_low, in_phase, ma_hi, ma_lo, c2, c1, c0, lock_ind, por;
  logic cur_sel, tri_t, drv_off, drv_en;
  int fails = 0;
  int comparisons = 0;
  int seed = 32'hb3d2;
  // Wired-AND data line: low if either side pulls
  assign sda_in = m_sda & (sda_oe_n | sda_out);
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  sld_bus_master m_u (.core_clk(core_clk), .scl(scl), .sda_drv(m_sda), .sda_bus(sda_in));
  sld_top #(.PERIOD_CYC(P)) dut_u (.core_clk(core_clk), .reset_n(reset_n), .scl_pin(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .analog_sense_pin(sense),
    .address_select_pin(adr_pin), .port_input(port_in), .supply_low(supply_low),
    .loop_in_phase(in_phase), .address_select_bit_hi(ma_hi), .address_select_bit_lo(ma_lo),
    .conversion_code_bit2(c2), .conversion_code_bit1(c1), .conversion_code_bit0(c0),
    .phase_locked_indicator(lock_ind), .power_on_flag(por), .pump_current_select(cur_sel),
    .pump_tristate_test(tri_t), .drive_disable(drv_off), .tuning_drive_enable(drv_en));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Lowest pin band wins, no band means open
  function automatic logic [1:0] exp_ma(input logic [2:0] p);
    return p[0] ? 2'h0 : p[1] ? 2'h2 : p[2] ? 2'h3 : 2'h1;
  endfunction
  function automatic logic [2:0] exp_code(input logic [3:0] s);
    return s[3] ? 3'h4 : s[2] ? 3'h3 : s[1] ? 3'h2 : s[0] ? 3'h1 : 3'h0;
  endfunction
  function automatic logic [2:0] pin_of(input logic [1:0] m);
    return (m == 2'h0) ? 3'h1 : (m == 2'h1) ? 3'h0 : (m == 2'h2) ? 3'h2 : 3'h4;
  endfunction
  task automatic wr(input logic [7:0] adr, input logic [31:0] d, input int n, input logic ea);
    logic ak;
    m_u.start();
    m_u.send(adr, ak);
    chk("addr_ack", {7'h0, ak}, {7'h0, ea});
    for (int i = 0; i < n && ak; i++) begin
      m_u.send(d[31 - 8 * i -: 8], ak);
      chk("data_ack", {7'h0, ak}, 8'h01);
    end
    m_u.stop();
    step(4);
  endtask
  task automatic rd(input int n, input logic [7:0] exp);
    logic ak;
    logic [7:0] st;
    m_u.start();
    m_u.send(8'hC3, ak);
    chk("rd_ack", {7'h0, ak}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m_u.recv(i == n - 1, st);
      chk("status", st, exp);
    end
    m_u.stop();
    step(2);
  endtask
  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Run needs about 0.5 ms; anything far beyond that is a hang
  initial begin
    #3_000_000;
    fails++;
    test_done();
  end
  initial begin
    int n;
    logic [7:0] ctl;
    logic [7:0] stv;
    reset_n = 1'h0;
    sense = 4'h0;
    adr_pin = 3'h0;
    port_in = 3'h0;
    supply_low = 1'h0;
    in_phase = 1'h0;
    e3 = 3'h0;
    step(3);
    reset_n = 1'h1;
    step(6);
    chk("por", {7'h0, por}, 8'h01);
    chk("lock_ind", {7'h0, lock_ind}, 8'h00);
    chk("ctl", {5'h0, cur_sel, tri_t, drv_off}, 8'h00);
    chk("drv_en", {7'h0, drv_en}, 8'h01);
    chk("sda_oe_n", {7'h0, sda_oe_n}, 8'h01);
    chk("sda_out", {7'h0, sda_out}, 8'h00);
    $display("test reset done");
    // Every band of both pins first, then random levels
    for (int i = 0; i < 16; i++) begin
      adr_pin = (i < 4) ? pin_of(i[1:0]) : 3'($random(seed));
      sense = (i < 5) ? 4'hF >> (4 - i) : 4'($random(seed));
      port_in = 3'($random(seed));
      step(4);
      chk("ma", {6'h0, ma_hi, ma_lo}, {6'h0, exp_ma(adr_pin)});
      chk("code", {5'h0, c2, c1, c0}, {5'h0, exp_code(sense)});
    end
    $display("test decode done");
    // Each address setting: a foreign address is ignored, own one takes the byte
    for (int i = 0; i < 8; i++) begin
      adr_pin = pin_of(i[1:0]);
      m_u.slow = i[2];
      r = 3'(i * 5);
      ctl = {1'h1, r[2], 1'h0, r[1], 3'h7, r[0]};
      step(4);
      wr({5'h18, i[1:0] ^ 2'(i[0] + 1), 1'h0}, {ctl ^ 8'h51, 24'h0}, 2, 1'h0);
      chk("ctl_kept", {5'h0, cur_sel, tri_t, drv_off}, {5'h0, e3});
      wr({5'h18, i[1:0], 1'h0}, (i == 7) ? {16'h05A0, ctl, 8'h00} : {ctl, 24'h0},
        (i == 7) ? 4 : 2, 1'h1);
      e3 = r;
      chk("ctl", {5'h0, cur_sel, tri_t, drv_off}, {5'h0, e3});
      chk("drv_en", {7'h0, drv_en}, {7'h0, ~r[0]});
    end
    m_u.slow = 1'h0;
    $display("test write done");
    adr_pin = 3'h0;
    port_in = 3'($random(seed));
    sense = 4'($random(seed));
    step(4);
    stv = {2'h2, port_in, exp_code(sense)};
    rd(2, stv);
    chk("por_clr", {7'h0, por}, 8'h00);
    rd(1, {1'h0, stv[6:0]});
    supply_low = 1'h1;
    step(2);
    supply_low = 1'h0;
    step(2);
    chk("por_set", {7'h0, por}, 8'h01);
    $display("test read done");
    // A short slip mid count must restart the clean-period count
    in_phase = 1'h1;
    step(5 * P);
    in_phase = 1'h0;
    step(3);
    in_phase = 1'h1;
    n = 0;
    while (lock_ind !== 1'h1 && n < 20 * P) begin
      step(1);
      n++;
    end
    chk("lock_min", 8'(n >= 8 * P), 8'h01);
    chk("lock_max", 8'(n <= 9 * P + 8), 8'h01);
    rd(1, {2'h3, stv[5:0]});
    in_phase = 1'h0;
    n = 0;
    while (lock_ind !== 1'h0 && n < 4 * P) begin
      step(1);
      n++;
    end
    chk("unlock", 8'(n <= P), 8'h01);
    $display("test lock done");
    test_done();
  end
endmodule // synth_status_lock_detect_tb_top
`default_nettype wire
